//--- usbe_engine.sv
// Purpose: Device-side endpoint engine: tokens, SRAM DMA, handshakes, queue
// Assumes: Packet layer on the same clock decodes tokens and serialises bytes
// Notes: Bus state pins are synchronised; one clock domain only
//
// Summary of operation
// - Works as full or low speed device; speed chosen by control bit.
// - Sixteen endpoint addresses, one in and one out endpoint each.
// - Each endpoint entry selects control, interrupt, bulk or isochronous type.
// - Maximum packet size per endpoint, up to 1023 bytes.
// - No local buffers; entries and data live in SRAM at software base.
// - Own DMA moves packet bytes between bus and SRAM buffers.
// - Own DMA fetches and writes back endpoint entries in SRAM.
// - Ping-pong pairs both entries in one direction, alternating banks.
// - Multipacket splits large payloads into packets without software.
// - Multipacket raises no completion event until the whole payload or a short packet ends it.
// - Completed transactions queue in a first-come, first-served FIFO.
// - Idle bus suspend may request sleep of the microcontroller.
// - Bus resume wakes the microcontroller.
// - Clock source select is its own field, apart from system clock.
// - Event pulses mark completions and setup packets.
`timescale 1ns/1ns
`include "usbe_map.svh"

module usbe_engine
(
	// Clock and reset
	input wire logic i_sys_clk,
	input wire logic i_rst,
	// Register port
	input wire logic [3:0] i_reg_addr,
	input wire logic [15:0] i_reg_wdata,
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	output logic [15:0] o_reg_rdata,
	// Tokens from packet layer
	input wire logic i_tok_valid,
	input wire logic [3:0] i_tok_pid,
	input wire logic [6:0] i_tok_addr,
	input wire logic [3:0] i_tok_ep,
	// Received data bytes
	input wire logic i_rx_valid,
	input wire logic [7:0] i_rx_data,
	input wire logic i_rx_end,
	input wire logic i_rx_err,
	// Transmit data bytes
	output logic o_tx_valid,
	output logic [7:0] o_tx_data,
	output logic o_tx_last,
	input wire logic i_tx_ready,
	// Handshake request
	output logic o_hs_valid,
	output logic [3:0] o_hs_pid,
	// SRAM port, read data in the same cycle as o_mem_re
	output logic [15:0] o_mem_addr,
	output logic [7:0] o_mem_wdata,
	output logic o_mem_we,
	output logic o_mem_re,
	input wire logic [7:0] i_mem_rdata,
	// Bus line state pins
	input wire logic i_bus_suspend,
	input wire logic i_bus_resume,
	// System side
	output logic o_low_speed,
	output logic [1:0] o_clk_sel,
	output logic o_sleep_ok,
	output logic o_wake,
	output logic o_evt_tc,
	output logic o_evt_setup,
	output logic o_irq
);

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	usbe_pkg::usbe_state_t state_reg;
	logic [4:0] ctrl_reg;
	logic [6:0] dev_addr_reg;
	logic [15:0] epbase_reg;
	logic [15:0] ppen_reg;
	logic [15:0] bank_reg;
	logic [4:0] status_reg;
	logic [4:0] mask_reg;
	logic [4:0] status_set;
	logic [3:0] ep_reg;
	logic dir_reg;
	logic setup_reg;
	logic [15:0] ent_addr_reg;
	logic [3:0] idx_reg;
	logic cap_reg;
	logic [71:0] cfg_reg;
	logic [15:0] j_reg;
	logic [15:0] len_reg;
	logic rx_ovf_reg;
	logic nak_pulse_reg;
	logic tc_push_reg;
	logic [4:0] tc_mem [0:`USBE_TC_DEPTH-1];
	logic [2:0] tc_wr_reg;
	logic [2:0] tc_rd_reg;
	logic [3:0] tc_cnt_reg;
	logic tc_pop;
	logic tc_ovf;
	logic [1:0] susp_sync_reg;
	logic [1:0] res_sync_reg;
	logic susp_d_reg;
	logic res_d_reg;
	logic susp_rise;
	logic res_rise;
	logic tok_hit;
	logic tok_in;
	logic ent_sel;
	logic c_ready;
	logic c_mp;
	usbe_pkg::usbe_xfer_t c_type;
	logic [15:0] c_max;
	logic [15:0] c_buf;
	logic [15:0] c_cnt;
	logic [15:0] c_tot;
	logic [15:0] c_off;
	logic [15:0] c_rem;
	logic [15:0] in_len;
	logic [15:0] new_cnt;
	logic xfer_done;

	// ----------------------------------------
	// Entry fields and packet arithmetic
	// ----------------------------------------
	assign c_ready = cfg_reg[`USBE_C_READY];
	assign c_mp = cfg_reg[`USBE_C_MP];
	assign c_type = usbe_pkg::usbe_xfer_t'(cfg_reg[`USBE_C_TYPE_HI:`USBE_C_TYPE_LO]);
	assign c_max = {6'h00, cfg_reg[17:8]};
	assign c_buf = cfg_reg[39:24];
	assign c_cnt = cfg_reg[55:40];
	assign c_tot = cfg_reg[71:56];
	assign c_off = c_mp ? c_cnt : `USBE_ZERO16;
	assign c_rem = c_tot - c_cnt;
	// Non-multipacket IN sends the count field, clamped to max size
	assign in_len = c_mp ? ((c_rem > c_max) ? c_max : c_rem)
		: ((c_cnt > c_max) ? c_max : c_cnt);
	assign new_cnt = c_mp ? c_cnt + j_reg : j_reg;
	// Short packet also ends a multipacket transfer
	assign xfer_done = !c_mp || (new_cnt >= c_tot) || (j_reg < c_max);

	assign tok_in = (i_tok_pid == `USBE_PID_IN);
	assign ent_sel = ppen_reg[i_tok_ep] ? bank_reg[i_tok_ep] : tok_in;
	assign tok_hit = i_tok_valid && ctrl_reg[`USBE_CTRL_EN] && (i_tok_addr == dev_addr_reg)
		&& (tok_in || (i_tok_pid == `USBE_PID_OUT) || (i_tok_pid == `USBE_PID_SETUP));

	// ----------------------------------------
	// Transaction sequencer and SRAM DMA
	// ----------------------------------------
	always_ff @(posedge i_sys_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			state_reg <= usbe_pkg::S_IDLE;
			ep_reg <= 4'h0;
			dir_reg <= 1'b0;
			setup_reg <= 1'b0;
			ent_addr_reg <= 16'h0000;
			idx_reg <= 4'h0;
			cap_reg <= 1'b0;
			cfg_reg <= 72'h00_0000_0000_0000_0000;
			j_reg <= 16'h0000;
			len_reg <= 16'h0000;
			rx_ovf_reg <= 1'b0;
			nak_pulse_reg <= 1'b0;
			tc_push_reg <= 1'b0;
			bank_reg <= 16'h0000;
			o_mem_addr <= 16'h0000;
			o_mem_wdata <= 8'h00;
			o_mem_we <= 1'b0;
			o_mem_re <= 1'b0;
			o_tx_valid <= 1'b0;
			o_tx_data <= 8'h00;
			o_tx_last <= 1'b0;
			o_hs_valid <= 1'b0;
			o_hs_pid <= 4'h0;
			o_evt_setup <= 1'b0;
		end
		else
		begin
			o_mem_we <= 1'b0;
			o_mem_re <= 1'b0;
			o_hs_valid <= 1'b0;
			nak_pulse_reg <= 1'b0;
			tc_push_reg <= 1'b0;
			o_evt_setup <= 1'b0;
			rx_ovf_reg <= 1'b0;
			case (state_reg)
				usbe_pkg::S_IDLE:
				begin
					if (tok_hit)
					begin
						ep_reg <= i_tok_ep;
						dir_reg <= tok_in;
						setup_reg <= (i_tok_pid == `USBE_PID_SETUP);
						ent_addr_reg <= epbase_reg + {7'h00, i_tok_ep, ent_sel, 4'h0};
						idx_reg <= 4'h0;
						state_reg <= usbe_pkg::S_FETCH;
					end
				end
				usbe_pkg::S_FETCH:
				begin
					// One byte per cycle; data lands one cycle behind the read
					o_mem_re <= (idx_reg < `USBE_ENT_BYTES);
					o_mem_addr <= ent_addr_reg + {12'h000, idx_reg};
					cap_reg <= (idx_reg < `USBE_ENT_BYTES);
					if (idx_reg < `USBE_ENT_BYTES)
						idx_reg <= idx_reg + 4'h1;
					if (cap_reg)
						cfg_reg <= {i_mem_rdata, cfg_reg[71:8]};
					if (cap_reg && (idx_reg == `USBE_ENT_BYTES))
						state_reg <= usbe_pkg::S_DEC;
				end
				usbe_pkg::S_DEC:
				begin
					cap_reg <= 1'b0;
					j_reg <= 16'h0000;
					len_reg <= in_len;
					if (!c_ready)
						state_reg <= (c_type == usbe_pkg::XFER_ISO) ? usbe_pkg::S_IDLE
							: usbe_pkg::S_NAK;
					else if (dir_reg)
						state_reg <= (in_len == 16'h0000) ? usbe_pkg::S_WB : usbe_pkg::S_TXRD;
					else
						state_reg <= usbe_pkg::S_RXD;
				end
				usbe_pkg::S_NAK:
				begin
					o_hs_valid <= 1'b1;
					o_hs_pid <= `USBE_PID_NAK;
					nak_pulse_reg <= 1'b1;
					state_reg <= usbe_pkg::S_IDLE;
				end
				usbe_pkg::S_TXRD:
				begin
					o_mem_re <= 1'b1;
					o_mem_addr <= c_buf + c_off + j_reg;
					state_reg <= usbe_pkg::S_TXLD;
				end
				usbe_pkg::S_TXLD:
				begin
					o_tx_data <= i_mem_rdata;
					o_tx_valid <= 1'b1;
					o_tx_last <= (j_reg == len_reg - 16'h0001);
					state_reg <= usbe_pkg::S_TXOUT;
				end
				usbe_pkg::S_TXOUT:
				begin
					if (i_tx_ready)
					begin
						o_tx_valid <= 1'b0;
						o_tx_last <= 1'b0;
						j_reg <= j_reg + 16'h0001;
						state_reg <= o_tx_last ? usbe_pkg::S_WB : usbe_pkg::S_TXRD;
					end
				end
				usbe_pkg::S_RXD:
				begin
					if (i_rx_err)
						state_reg <= usbe_pkg::S_IDLE;
					else if (i_rx_end)
						state_reg <= (c_type == usbe_pkg::XFER_ISO) ? usbe_pkg::S_WB
							: usbe_pkg::S_ACK;
					else if (i_rx_valid)
					begin
						// Bytes beyond max size are dropped and flagged
						if (j_reg < c_max)
						begin
							o_mem_we <= 1'b1;
							o_mem_addr <= c_buf + c_off + j_reg;
							o_mem_wdata <= i_rx_data;
							j_reg <= j_reg + 16'h0001;
						end
						else
							rx_ovf_reg <= 1'b1;
					end
				end
				usbe_pkg::S_ACK:
				begin
					o_hs_valid <= 1'b1;
					o_hs_pid <= `USBE_PID_ACK;
					o_evt_setup <= setup_reg;
					state_reg <= usbe_pkg::S_WB;
				end
				usbe_pkg::S_WB:
				begin
					// Write back control, then count low and high bytes
					o_mem_we <= 1'b1;
					idx_reg <= idx_reg + 4'h1;
					if (idx_reg == 4'h0)
					begin
						o_mem_addr <= ent_addr_reg;
						o_mem_wdata <= {cfg_reg[7:5], cfg_reg[`USBE_C_DONE] | xfer_done,
							cfg_reg[3:1], c_ready & ~xfer_done};
					end
					else if (idx_reg == 4'h1)
					begin
						o_mem_addr <= ent_addr_reg + {12'h000, `USBE_ENT_CNT_LO};
						o_mem_wdata <= new_cnt[7:0];
					end
					else
					begin
						o_mem_addr <= ent_addr_reg + {12'h000, `USBE_ENT_CNT_HI};
						o_mem_wdata <= new_cnt[15:8];
						// Completion event only when the transfer completes, in full or by a short packet
						tc_push_reg <= xfer_done;
						if (xfer_done && ppen_reg[ep_reg])
							bank_reg[ep_reg] <= ~bank_reg[ep_reg];
						state_reg <= usbe_pkg::S_IDLE;
					end
				end
				default:
					state_reg <= usbe_pkg::S_IDLE;
			endcase
			// Entering write-back always starts at the control byte
			if (state_reg == usbe_pkg::S_DEC)
				idx_reg <= 4'h0;
		end
	end

	// ----------------------------------------
	// Transaction-complete queue
	// ----------------------------------------
	assign tc_pop = i_reg_rd && (i_reg_addr == `USBE_R_TCFIFO) && (tc_cnt_reg != 4'h0);
	assign tc_ovf = tc_push_reg && (tc_cnt_reg == `USBE_TC_FULL) && !tc_pop;

	always_ff @(posedge i_sys_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			tc_wr_reg <= 3'h0;
			tc_rd_reg <= 3'h0;
			tc_cnt_reg <= 4'h0;
		end
		else
		begin
			if (tc_push_reg && !tc_ovf)
				tc_wr_reg <= tc_wr_reg + 3'h1;
			if (tc_pop)
				tc_rd_reg <= tc_rd_reg + 3'h1;
			if (tc_push_reg && !tc_ovf && !tc_pop)
				tc_cnt_reg <= tc_cnt_reg + 4'h1;
			else if (tc_pop && !tc_push_reg)
				tc_cnt_reg <= tc_cnt_reg - 4'h1;
		end
	end

	genvar g;
	generate
		for (g = 0; g < `USBE_TC_DEPTH; g = g + 1)
		begin : g_tc
			always_ff @(posedge i_sys_clk or posedge i_rst)
			begin
				if (i_rst)
					tc_mem[g] <= 5'h00;
				else if (tc_push_reg && !tc_ovf && (tc_wr_reg == 3'(g)))
					tc_mem[g] <= {ep_reg, dir_reg};
			end
		end
	endgenerate

	// ----------------------------------------
	// Bus state synchronisers and sleep control
	// ----------------------------------------
	always_ff @(posedge i_sys_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			susp_sync_reg <= 2'h0;
			res_sync_reg <= 2'h0;
			susp_d_reg <= 1'b0;
			res_d_reg <= 1'b0;
			o_wake <= 1'b0;
			o_sleep_ok <= 1'b0;
		end
		else
		begin
			susp_sync_reg <= {susp_sync_reg[0], i_bus_suspend};
			res_sync_reg <= {res_sync_reg[0], i_bus_resume};
			susp_d_reg <= susp_sync_reg[1];
			res_d_reg <= res_sync_reg[1];
			// Sleep allowed only while suspended and the engine is idle
			o_sleep_ok <= ctrl_reg[`USBE_CTRL_SLEEP] && susp_sync_reg[1]
				&& (state_reg == usbe_pkg::S_IDLE);
			o_wake <= res_rise;
		end
	end

	assign susp_rise = susp_sync_reg[1] && !susp_d_reg;
	assign res_rise = res_sync_reg[1] && !res_d_reg;

	// ----------------------------------------
	// Status, mask and interrupt
	// ----------------------------------------
	always_comb
	begin
		status_set = 5'h00;
		status_set[`USBE_ST_TC] = tc_push_reg;
		status_set[`USBE_ST_SUSP] = susp_rise;
		status_set[`USBE_ST_RES] = res_rise;
		status_set[`USBE_ST_NAK] = nak_pulse_reg;
		status_set[`USBE_ST_OVF] = tc_ovf || rx_ovf_reg;
	end

	always_ff @(posedge i_sys_clk or posedge i_rst)
	begin
		if (i_rst)
			status_reg <= 5'h00;
		else if (i_reg_wr && (i_reg_addr == `USBE_R_STATUS))
			// A new event wins over a clear in the same cycle
			status_reg <= (status_reg & ~i_reg_wdata[4:0]) | status_set;
		else
			status_reg <= status_reg | status_set;
	end

	assign o_irq = |(status_reg & mask_reg);
	assign o_evt_tc = tc_push_reg;

	// ----------------------------------------
	// Register writes
	// ----------------------------------------
	always_ff @(posedge i_sys_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			ctrl_reg <= `USBE_CTRL_RST;
			dev_addr_reg <= 7'h00;
			epbase_reg <= 16'h0000;
			ppen_reg <= 16'h0000;
			mask_reg <= 5'h00;
		end
		else if (i_reg_wr)
		begin
			if (i_reg_addr == `USBE_R_CTRL)
				ctrl_reg <= i_reg_wdata[4:0];
			else if (i_reg_addr == `USBE_R_ADDR)
				dev_addr_reg <= i_reg_wdata[6:0];
			else if (i_reg_addr == `USBE_R_EPBASE)
				epbase_reg <= i_reg_wdata;
			else if (i_reg_addr == `USBE_R_PPEN)
				ppen_reg <= i_reg_wdata;
			else if (i_reg_addr == `USBE_R_MASK)
				mask_reg <= i_reg_wdata[4:0];
		end
	end

	assign o_low_speed = ctrl_reg[`USBE_CTRL_LS];
	assign o_clk_sel = ctrl_reg[`USBE_CTRL_CLK_HI:`USBE_CTRL_CLK_LO];

	// ----------------------------------------
	// Register reads, data one cycle after the strobe
	// ----------------------------------------
	always_ff @(posedge i_sys_clk or posedge i_rst)
	begin
		if (i_rst)
			o_reg_rdata <= 16'h0000;
		else if (i_reg_rd)
		begin
			if (i_reg_addr == `USBE_R_CTRL)
				o_reg_rdata <= {11'h000, ctrl_reg};
			else if (i_reg_addr == `USBE_R_ADDR)
				o_reg_rdata <= {9'h000, dev_addr_reg};
			else if (i_reg_addr == `USBE_R_EPBASE)
				o_reg_rdata <= epbase_reg;
			else if (i_reg_addr == `USBE_R_PPEN)
				o_reg_rdata <= ppen_reg;
			else if (i_reg_addr == `USBE_R_STATUS)
				o_reg_rdata <= {11'h000, status_reg};
			else if (i_reg_addr == `USBE_R_MASK)
				o_reg_rdata <= {11'h000, mask_reg};
			else if (i_reg_addr == `USBE_R_TCFIFO)
				o_reg_rdata <= {10'h000, (tc_cnt_reg != 4'h0), tc_mem[tc_rd_reg]};
			else if (i_reg_addr == `USBE_R_TCCNT)
				o_reg_rdata <= {12'h000, tc_cnt_reg};
			else
				o_reg_rdata <= 16'h0000;
		end
	end

endmodule : usbe_engine

//--- usbe_map.svh
// Purpose: Register offsets, field positions and codes of the endpoint engine
// Assumes: Included by bare name; definitions only
// Notes: Endpoint entries are 16-byte strides in SRAM, 9 bytes used
`ifndef USBE_MAP_SVH
`define USBE_MAP_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define USBE_R_CTRL 4'h0
`define USBE_R_ADDR 4'h1
`define USBE_R_EPBASE 4'h2
`define USBE_R_PPEN 4'h3
`define USBE_R_STATUS 4'h4
`define USBE_R_MASK 4'h5
`define USBE_R_TCFIFO 4'h6
`define USBE_R_TCCNT 4'h7

// ----------------------------------------
// Control register fields and reset values
// ----------------------------------------
`define USBE_CTRL_EN 0
`define USBE_CTRL_LS 1
`define USBE_CTRL_CLK_LO 2
`define USBE_CTRL_CLK_HI 3
`define USBE_CTRL_SLEEP 4
`define USBE_CTRL_RST 5'h00
`define USBE_ZERO16 16'h0000

// ----------------------------------------
// Status bits
// ----------------------------------------
`define USBE_ST_TC 0
`define USBE_ST_SUSP 1
`define USBE_ST_RES 2
`define USBE_ST_NAK 3
`define USBE_ST_OVF 4

// ----------------------------------------
// Endpoint entry layout (byte index in entry, bit in control byte)
// ----------------------------------------
`define USBE_ENT_BYTES 4'h9
`define USBE_ENT_CNT_LO 4'h5
`define USBE_ENT_CNT_HI 4'h6
`define USBE_C_READY 0
`define USBE_C_TYPE_LO 1
`define USBE_C_TYPE_HI 2
`define USBE_C_MP 3
`define USBE_C_DONE 4

// ----------------------------------------
// Token and handshake codes
// ----------------------------------------
`define USBE_PID_OUT 4'h1
`define USBE_PID_IN 4'h9
`define USBE_PID_SETUP 4'hD
`define USBE_PID_ACK 4'h2
`define USBE_PID_NAK 4'hA

// ----------------------------------------
// Transaction-complete queue
// ----------------------------------------
`define USBE_TC_DEPTH 8
`define USBE_TC_FULL 4'h8

`endif

//--- usbe_pkg.sv
// Purpose: Types shared by the endpoint engine
// Assumes: Used by scoped name only
// Notes: States are one-hot
package usbe_pkg;

	typedef enum logic [9:0]
	{
		S_IDLE = 10'h001,
		S_FETCH = 10'h002,
		S_DEC = 10'h004,
		S_NAK = 10'h008,
		S_TXRD = 10'h010,
		S_TXLD = 10'h020,
		S_TXOUT = 10'h040,
		S_RXD = 10'h080,
		S_ACK = 10'h100,
		S_WB = 10'h200
	} usbe_state_t;

	typedef enum logic [1:0]
	{
		XFER_CTRL = 2'h0,
		XFER_INT = 2'h1,
		XFER_BULK = 2'h2,
		XFER_ISO = 2'h3
	} usbe_xfer_t;

endpackage : usbe_pkg

//--- usbe_engine_asserts.sv
// Purpose: Concurrent checks on the endpoint engine ports
// Assumes: Bound to every usbe_engine instance
// Notes: Sees only top-level ports, so register internals are not visible
`timescale 1ns/1ns
`include "usbe_map.svh"

module usbe_engine_asserts
(
	// Clock and reset
	input wire logic i_sys_clk,
	input wire logic i_rst,
	// Register port
	input wire logic [3:0] i_reg_addr,
	input wire logic [15:0] i_reg_wdata,
	input wire logic i_reg_wr,
	// Packet side
	input wire logic o_tx_valid,
	input wire logic [7:0] o_tx_data,
	input wire logic o_tx_last,
	input wire logic i_tx_ready,
	input wire logic o_hs_valid,
	input wire logic [3:0] o_hs_pid,
	// Memory and system side
	input wire logic o_mem_we,
	input wire logic o_mem_re,
	input wire logic i_bus_suspend,
	input wire logic o_low_speed,
	input wire logic [1:0] o_clk_sel,
	input wire logic o_sleep_ok,
	input wire logic o_wake,
	input wire logic o_evt_tc,
	input wire logic o_irq
);
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	default clocking cb @(posedge i_sys_clk);
	endclocking
	default disable iff (i_rst);

	wire ctrl_wr = i_reg_wr && (i_reg_addr == `USBE_R_CTRL);
	wire mask_clr = i_reg_wr && (i_reg_addr == `USBE_R_MASK) && (i_reg_wdata == 16'h0000);

	property p_ls;
		ctrl_wr |=> o_low_speed == $past(i_reg_wdata[`USBE_CTRL_LS]);
	endproperty
	a_ls: assert property (p_ls) else $error("speed select not taken");
	property p_clk;
		ctrl_wr |=> o_clk_sel == $past(i_reg_wdata[3:2]);
	endproperty
	a_clk: assert property (p_clk) else $error("clock select not taken");
	property p_hs_one;
		o_hs_valid |=> !o_hs_valid;
	endproperty
	a_hs_one: assert property (p_hs_one) else $error("handshake too long");
	property p_hs_code;
		o_hs_valid |-> (o_hs_pid == `USBE_PID_ACK) || (o_hs_pid == `USBE_PID_NAK);
	endproperty
	a_hs_code: assert property (p_hs_code) else $error("bad handshake code");
	property p_tx_hold;
		o_tx_valid && !i_tx_ready |=> o_tx_valid && $stable(o_tx_data) && $stable(o_tx_last);
	endproperty
	a_tx_hold: assert property (p_tx_hold) else $error("tx byte dropped");
	property p_tx_src;
		$rose(o_tx_valid) |-> $past(o_mem_re);
	endproperty
	a_tx_src: assert property (p_tx_src) else $error("tx byte without fetch");
	property p_mem_one;
		!(o_mem_we && o_mem_re);
	endproperty
	a_mem_one: assert property (p_mem_one) else $error("read and write at once");
	property p_tc;
		o_evt_tc |-> $past(o_mem_we) ##1 !o_evt_tc;
	endproperty
	a_tc: assert property (p_tc) else $error("completion not after write-back");
	property p_wake;
		o_wake |=> !o_wake;
	endproperty
	a_wake: assert property (p_wake) else $error("wake too long");
	property p_sleep;
		!i_bus_suspend [*4] |-> !o_sleep_ok;
	endproperty
	a_sleep: assert property (p_sleep) else $error("sleep without suspend");
	property p_irq;
		mask_clr |=> !o_irq;
	endproperty
	a_irq: assert property (p_irq) else $error("irq while all masked");

	c_nak: cover property (o_hs_valid && o_hs_pid == `USBE_PID_NAK);
	c_last: cover property (o_tx_valid && o_tx_last && i_tx_ready);
	c_tc: cover property (o_evt_tc);
endmodule : usbe_engine_asserts

bind usbe_engine usbe_engine_asserts usbe_engine_asserts_inst (.*);

//--- usbe_host_model.sv
// Purpose: Host side of the packet layer: tokens, data packets, tx pacing
// Assumes: Tasks called from the bench, all changes just after a rising edge
// Notes: Released lines show inverted values, never the last one
`timescale 1ns/1ns

module usbe_host_model
(
	// Clock
	input wire logic i_sys_clk,
	// Token lines
	output logic o_tok_valid,
	output logic [3:0] o_tok_pid,
	output logic [6:0] o_tok_addr,
	output logic [3:0] o_tok_ep,
	// Data packet lines
	output logic o_rx_valid,
	output logic [7:0] o_rx_data,
	output logic o_rx_end,
	output logic o_rx_err,
	// Transmit pacing
	output logic o_tx_ready
);
	// ----------------------------------------
	// Behaviour
	// ----------------------------------------
	logic [1:0] pace = 2'h0;
	initial {o_tok_valid, o_tok_pid, o_tok_addr, o_tok_ep} = 16'h0000;
	initial {o_rx_valid, o_rx_data, o_rx_end, o_rx_err, o_tx_ready} = 12'h000;

	// Stall one cycle in four so slow and prompt acceptance both occur
	always @(posedge i_sys_clk)
	begin
		pace <= pace + 2'h1;
		o_tx_ready <= (pace != 2'h3);
	end

	task automatic send_token(input logic [3:0] pid, input logic [6:0] a, input logic [3:0] ep);
		@(posedge i_sys_clk);
		o_tok_valid <= 1'b1;
		{o_tok_pid, o_tok_addr, o_tok_ep} <= {pid, a, ep};
		@(posedge i_sys_clk);
		o_tok_valid <= 1'b0;
		{o_tok_pid, o_tok_addr, o_tok_ep} <= ~{pid, a, ep};
	endtask : send_token

	// Waits out the entry fetch; earlier bytes would be lost
	task automatic send_data(input logic [7:0] b [3], input logic bad);
		repeat (12) @(posedge i_sys_clk);
		for (int k = 0; k < 3; k++)
		begin
			o_rx_valid <= 1'b1;
			o_rx_data <= b[k];
			@(posedge i_sys_clk);
		end
		o_rx_valid <= 1'b0;
		o_rx_data <= ~b[2];
		o_rx_end <= !bad;
		o_rx_err <= bad;
		@(posedge i_sys_clk);
		{o_rx_end, o_rx_err} <= 2'b00;
	endtask : send_data
endmodule : usbe_host_model

//--- usbe_engine_tb_top.sv
// Purpose: Self-checking bench for the endpoint engine
// Assumes: 10 MHz clock, SRAM modelled here, host in its own model
// Notes: Expected results queue up; a negedge monitor retires them
`timescale 1ns/1ns
`include "usbe_map.svh"

module usbe_engine_tb_top;
	// ----------------------------------------
	// Signals and models
	// ----------------------------------------
	logic i_sys_clk, i_rst, i_reg_wr, i_reg_rd, i_bus_suspend, i_bus_resume;
	logic [3:0] i_reg_addr;
	logic [15:0] i_reg_wdata, o_reg_rdata, o_mem_addr;
	logic i_tok_valid, i_rx_valid, i_rx_end, i_rx_err, i_tx_ready;
	logic [3:0] i_tok_pid, i_tok_ep, o_hs_pid;
	logic [6:0] i_tok_addr;
	logic [7:0] i_rx_data, o_tx_data, o_mem_wdata, i_mem_rdata;
	logic o_tx_valid, o_tx_last, o_hs_valid, o_mem_we, o_mem_re, o_low_speed;
	logic o_sleep_ok, o_wake, o_evt_tc, o_evt_setup, o_irq;
	logic [1:0] o_clk_sel;
	int n_fail = 0, checks_done = 0, n_tc = 0, n_wake = 0;
	logic [31:0] seed = 32'h67f6_7e9b;
	logic rd_q = 1'b0;
	logic [15:0] q_rd [$];
	logic [3:0] q_hs [$];
	logic [8:0] q_tx [$];
	logic [23:0] q_mem [$];
	logic [7:0] mem [logic [15:0]];
	logic [7:0] pk [3];

	usbe_engine usbe_engine_inst (.*);

	usbe_host_model usbe_host_model_inst (.i_sys_clk(i_sys_clk),
		.o_tok_valid(i_tok_valid), .o_tok_pid(i_tok_pid), .o_tok_addr(i_tok_addr),
		.o_tok_ep(i_tok_ep), .o_rx_valid(i_rx_valid), .o_rx_data(i_rx_data),
		.o_rx_end(i_rx_end), .o_rx_err(i_rx_err), .o_tx_ready(i_tx_ready));

	initial
	begin
		i_sys_clk = 1'b0;
		forever #50 i_sys_clk = ~i_sys_clk;
	end

	// SRAM: engine captures read data in the strobe cycle; idle shows a pattern
	always @(o_mem_re or o_mem_addr)
		i_mem_rdata = (o_mem_re && mem.exists(o_mem_addr)) ? mem[o_mem_addr] : ~o_mem_addr[7:0];
	always @(posedge i_sys_clk)
		if (o_mem_we)
			mem[o_mem_addr] = o_mem_wdata;

	// ----------------------------------------
	// Checking
	// ----------------------------------------
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : xs

	task automatic tally(input logic ok, input string m);
		checks_done++;
		if (ok !== 1'b1)
		begin
			n_fail++;
			$display("unexpected at %0t: %s", $time, m);
		end
	endtask : tally
	task automatic cmp_reg(input logic [15:0] g, input logic [15:0] e);
		tally(g === e, "register or pin value");
	endtask : cmp_reg
	task automatic cmp_hs(input logic [3:0] g, input logic [3:0] e);
		tally(g === e, "handshake code");
	endtask : cmp_hs
	task automatic cmp_tx(input logic [8:0] g, input logic [8:0] e);
		tally(g === e, "transmit byte");
	endtask : cmp_tx
	task automatic cmp_mem(input logic [23:0] g, input logic [23:0] e);
		tally(g === e, "memory write");
	endtask : cmp_mem

	always @(posedge i_sys_clk)
		rd_q <= i_reg_rd;
	always @(negedge i_sys_clk)
	begin
		if (rd_q)
			cmp_reg(o_reg_rdata, q_rd.pop_front());
		if (o_hs_valid === 1'b1)
			cmp_hs(o_hs_pid, q_hs.size() ? q_hs.pop_front() : 4'hx);
		if (o_tx_valid === 1'b1 && i_tx_ready)
			cmp_tx({o_tx_last, o_tx_data}, q_tx.size() ? q_tx.pop_front() : 9'hx);
		if (o_mem_we === 1'b1)
			cmp_mem({o_mem_addr, o_mem_wdata}, q_mem.size() ? q_mem.pop_front() : 24'hx);
		n_tc += int'(o_evt_tc === 1'b1);
		n_wake += int'(o_wake === 1'b1);
	end

	// ----------------------------------------
	// Stimulus tasks
	// ----------------------------------------
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge i_sys_clk);
		{i_reg_wr, i_reg_addr, i_reg_wdata} <= {1'b1, a, d};
		@(posedge i_sys_clk);
		i_reg_wr <= 1'b0;
		i_reg_wdata <= ~d;
	endtask : wr
	task automatic rd(input logic [3:0] a, input logic [15:0] e);
		q_rd.push_back(e);
		@(posedge i_sys_clk);
		{i_reg_rd, i_reg_addr} <= {1'b1, a};
		@(posedge i_sys_clk);
		i_reg_rd <= 1'b0;
	endtask : rd
	task automatic ent(input logic [15:0] a, input logic [7:0] c, input logic [7:0] mx,
		input logic [15:0] bf, input logic [7:0] cn);
		logic [7:0] b [9] = '{c, mx, 8'h00, bf[7:0], bf[15:8], cn, 8'h00, 8'h00, 8'h00};
		for (int k = 0; k < 9; k++)
			mem[a + 16'(k)] = b[k];
	endtask : ent
	task automatic drain(input string t);
		for (int k = 0; k < 400 && q_hs.size() + q_tx.size() + q_mem.size() > 0; k++)
			@(posedge i_sys_clk);
		repeat (3) @(posedge i_sys_clk);
		tally(q_hs.size() + q_tx.size() + q_mem.size() == 0, "results missing");
		$display("test %s done", t);
	endtask : drain
	task automatic results();
		$display("checks %0d failures %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : results

	initial
	begin
		#2_000_000;
		n_fail++;
		results();
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin
		{i_rst, i_reg_wr, i_reg_rd, i_bus_suspend, i_bus_resume} = 5'h10;
		{i_reg_addr, i_reg_wdata} = 20'h0_0000;
		repeat (10) @(posedge i_sys_clk);
		i_rst <= 1'b0;
		rd(`USBE_R_CTRL, 16'h0000);
		rd(4'h8, 16'h0000);
		wr(`USBE_R_ADDR, 16'h0005);
		wr(`USBE_R_EPBASE, 16'h0100);
		wr(`USBE_R_MASK, 16'h0001);
		wr(`USBE_R_CTRL, 16'h001B);
		@(negedge i_sys_clk);
		cmp_reg({14'h0000, o_clk_sel, o_low_speed}, 16'h0005);
		rd(`USBE_R_CTRL, 16'h001B);
		drain("registers");
		ent(16'h0170, 8'h00, 8'h08, 16'h0400, 8'h00);
		usbe_host_model_inst.send_token(`USBE_PID_IN, 7'h06, 4'h3);
		q_hs.push_back(`USBE_PID_NAK);
		usbe_host_model_inst.send_token(`USBE_PID_IN, 7'h05, 4'h3);
		drain("not ready");
		rd(`USBE_R_STATUS, 16'h0008);
		wr(`USBE_R_STATUS, 16'h0008);
		rd(`USBE_R_STATUS, 16'h0000);
		ent(16'h0120, 8'h05, 8'h08, 16'h0200, 8'h00);
		for (int k = 0; k < 3; k++)
		begin
			pk[k] = xs() >> 24;
			q_mem.push_back({16'h0200 + 16'(k), pk[k]});
		end
		q_mem.push_back(24'h0120_14);
		q_mem.push_back(24'h0125_03);
		q_mem.push_back(24'h0126_00);
		q_hs.push_back(`USBE_PID_ACK);
		usbe_host_model_inst.send_token(`USBE_PID_OUT, 7'h05, 4'h1);
		usbe_host_model_inst.send_data(pk, 1'b0);
		drain("out packet");
		cmp_reg({15'h0000, o_irq}, 16'h0001);
		wr(`USBE_R_STATUS, 16'h0001);
		@(negedge i_sys_clk);
		cmp_reg({15'h0000, o_irq}, 16'h0000);
		ent(16'h0120, 8'h05, 8'h08, 16'h0200, 8'h00);
		for (int k = 0; k < 3; k++)
			q_mem.push_back({16'h0200 + 16'(k), pk[k]});
		usbe_host_model_inst.send_token(`USBE_PID_OUT, 7'h05, 4'h1);
		usbe_host_model_inst.send_data(pk, 1'b1);
		drain("bad packet");
		ent(16'h0150, 8'h05, 8'h04, 16'h0300, 8'h03);
		for (int k = 0; k < 3; k++)
		begin
			mem[16'h0300 + 16'(k)] = xs() >> 24;
			q_tx.push_back({k == 2, mem[16'h0300 + 16'(k)]});
		end
		q_mem.push_back(24'h0150_14);
		q_mem.push_back(24'h0155_03);
		q_mem.push_back(24'h0156_00);
		usbe_host_model_inst.send_token(`USBE_PID_IN, 7'h05, 4'h2);
		drain("in packet");
		cmp_reg(16'(n_tc), 16'h0002);
		rd(`USBE_R_TCCNT, 16'h0002);
		rd(`USBE_R_TCFIFO, 16'h0022);
		rd(`USBE_R_TCFIFO, 16'h0025);
		rd(`USBE_R_TCFIFO, 16'h0000);
		rd(`USBE_R_TCCNT, 16'h0000);
		wr(`USBE_R_STATUS, 16'h0001);
		drain("completion queue");
		i_bus_suspend <= 1'b1;
		repeat (6) @(posedge i_sys_clk);
		cmp_reg({15'h0000, o_sleep_ok}, 16'h0001);
		{i_bus_suspend, i_bus_resume} <= 2'b01;
		repeat (6) @(posedge i_sys_clk);
		i_bus_resume <= 1'b0;
		cmp_reg({15'h0000, o_sleep_ok}, 16'h0000);
		cmp_reg(16'(n_wake), 16'h0001);
		rd(`USBE_R_STATUS, 16'h0006);
		wr(`USBE_R_MASK, 16'h0000);
		drain("suspend and resume");
		results();
	end
endmodule : usbe_engine_tb_top
